//--- src/mcsr_pkg.sv
// Package for the multichip sync receive block: register map, fields and timing constants.
// Assumes a 32-bit APB slave with word-aligned registers.
package mcsr_pkg;

  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_SYNC_CFG = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
  localparam logic [7:0] ADDR_STATUS = 8'h40;

  localparam int PN_ENABLE_BIT = 13;
  localparam int MODE_SEL_BIT = 12;
  localparam int PULSE_EN_BIT = 11;
  localparam int TXEN_INV_BIT = 14;

  localparam int SYNC_IN_EN_BIT = 26;
  localparam int DELAY_HI = 23;
  localparam int DELAY_LO = 19;
  localparam int CHK_MODE_BIT = 18;
  localparam int CLK_STATE_HI = 7;
  localparam int CLK_STATE_LO = 4;
  localparam int MARGIN_HI = 3;
  localparam int MARGIN_LO = 0;

  localparam int IRQ_EN_BIT = 0;
  localparam int ERR_TYPE_BIT = 4;
  localparam int ERR_FLAG_BIT = 6;

  localparam logic [31:0] CTRL1_RST = 32'h0000_0000;
  localparam logic [31:0] SYNC_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] PN_CODE_DEF = 32'hace1_35d9;

  localparam int CLK_STATES = 32;
  localparam int DELAY_TAPS = 32;

  typedef struct packed {
    logic pn_mode;
    logic pulse_en;
    logic sync_in_en;
    logic txen_invert;
    logic [3:0] clk_state;
    logic [4:0] delay;
    logic [3:0] margin;
  } mcsr_cfg_type;

endpackage

//--- src/mcsr_margin.sv
// Sync input delay line and margin monitor.
// Assumes sync_i is already synchronised to core_clk_i.
`timescale 1ns/1ps
module mcsr_margin #(
  parameter int TAPS = 32
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic sync_i,
  input wire logic [4:0] delay_i,
  input wire logic [3:0] margin_i,
  output logic sync_dly_o,
  output logic err_o,
  output logic err_hold_o
);
  logic [TAPS-1:0] line_r;
  logic [4:0] since_r;
  logic prev_r;
  wire edge_w = sync_dly_o & ~prev_r;
  wire [4:0] limit_w = {1'b0, margin_i};

  // The tap chosen by the delay field feeds the logic; zero is the shortest path.
  assign sync_dly_o = line_r[delay_i];

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      line_r <= '0;
      prev_r <= 1'b0;
      since_r <= '0;
    end
    else
    begin
      line_r <= {line_r[TAPS-2:0], sync_i};
      prev_r <= sync_dly_o;
      if (edge_w)
        since_r <= '0;
      else if (since_r != 5'h1_f)
        since_r <= since_r + 5'h0_1;
    end
  end

  // Setup margin is the edge coming too soon after the previous one; hold margin
  // is the pulse falling too soon after its own rise.
  assign err_o = (edge_w && since_r < limit_w) || (prev_r && !sync_dly_o && since_r < limit_w);
  assign err_hold_o = prev_r & ~sync_dly_o;
endmodule

//--- src/mcsr_top.sv
// Multichip sync receive: init pulse, 32-state clock generator, NCO reset, margin flag.
// Assumes an APB master on core_clk_i; sync and strobe pins come from outside.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module mcsr_top #(
  parameter int PN_LEN = 32,
  parameter logic [31:0] PN_CODE = mcsr_pkg::PN_CODE_DEF
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync_pin_i,
  input wire logic txen_pin_i,
  input wire logic data_clk_en_i,
  output logic init_pulse_o,
  output logic [4:0] clk_state_o,
  output logic nco_reset_o,
  output logic irq_n_o,
  output logic irq_n_oe_o
);
  logic [31:0] ctrl1_r;
  logic [31:0] cfg_r;
  logic irq_en_r;
  logic err_flag_r;
  logic err_type_r;
  logic [1:0] sync_meta_r;
  logic [1:0] txen_meta_r;
  logic sync_prev_r;
  logic txen_prev_r;
  logic [PN_LEN-1:0] pn_shift_r;
  logic [4:0] state_r;
  logic [4:0] state_nxt;
  logic init_r;
  logic nco_rst_r;
  logic sync_dly;
  logic marg_err;
  logic marg_hold;
  mcsr_pkg::mcsr_cfg_type cfg;

  assign cfg.pn_mode = ctrl1_r[mcsr_pkg::PN_ENABLE_BIT] & ctrl1_r[mcsr_pkg::MODE_SEL_BIT];
  assign cfg.pulse_en = ctrl1_r[mcsr_pkg::PULSE_EN_BIT] & ~ctrl1_r[mcsr_pkg::MODE_SEL_BIT];
  assign cfg.sync_in_en = cfg_r[mcsr_pkg::SYNC_IN_EN_BIT];
  assign cfg.txen_invert = ctrl1_r[mcsr_pkg::TXEN_INV_BIT];
  assign cfg.clk_state = cfg_r[mcsr_pkg::CLK_STATE_HI:mcsr_pkg::CLK_STATE_LO];
  assign cfg.delay = cfg_r[mcsr_pkg::DELAY_HI:mcsr_pkg::DELAY_LO];
  assign cfg.margin = cfg_r[mcsr_pkg::MARGIN_HI:mcsr_pkg::MARGIN_LO];

  // APB: zero wait states, unmapped addresses answer with an error.
  wire acc_w = psel & penable;
  wire wr_w = acc_w & pwrite;
  wire hit_ctrl1 = paddr == mcsr_pkg::ADDR_CTRL1;
  wire hit_cfg = paddr == mcsr_pkg::ADDR_SYNC_CFG;
  wire hit_irq = paddr == mcsr_pkg::ADDR_IRQ_STAT;
  wire hit_stat = paddr == mcsr_pkg::ADDR_STATUS;
  wire mapped_w = hit_ctrl1 | hit_cfg | hit_irq | hit_stat;
  wire clr_err_w = wr_w & hit_irq & pwdata[mcsr_pkg::ERR_FLAG_BIT];
  assign pready = 1'b1;
  assign pslverr = acc_w & ~mapped_w;

  always_comb
  begin
    prdata = 32'h0000_0000;
    if (hit_ctrl1)
      prdata = ctrl1_r;
    else if (hit_cfg)
      prdata = cfg_r;
    else if (hit_irq)
    begin
      prdata[mcsr_pkg::IRQ_EN_BIT] = irq_en_r;
      prdata[mcsr_pkg::ERR_TYPE_BIT] = err_type_r;
      prdata[mcsr_pkg::ERR_FLAG_BIT] = err_flag_r;
    end
    else if (hit_stat)
      prdata = {27'h000_0000, state_r};
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl1_r <= mcsr_pkg::CTRL1_RST;
      cfg_r <= mcsr_pkg::SYNC_CFG_RST;
      irq_en_r <= 1'b0;
    end
    else if (wr_w)
    begin
      if (hit_ctrl1)
        ctrl1_r <= pwdata;
      if (hit_cfg)
        cfg_r <= pwdata;
      if (hit_irq)
        irq_en_r <= pwdata[mcsr_pkg::IRQ_EN_BIT];
    end
  end

  // Pin inputs pass two flops; the sync pin is sampled on the sample clock only.
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_meta_r <= 2'b00;
      txen_meta_r <= 2'b00;
    end
    else
    begin
      sync_meta_r <= {sync_meta_r[0], sync_pin_i};
      txen_meta_r <= {txen_meta_r[0], txen_pin_i};
    end
  end

  mcsr_margin #(
    .TAPS(mcsr_pkg::DELAY_TAPS)
  ) u_margin (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .sync_i(sync_meta_r[1] & cfg.sync_in_en),
    .delay_i(cfg.delay),
    .margin_i(cfg.margin),
    .sync_dly_o(sync_dly),
    .err_o(marg_err),
    .err_hold_o(marg_hold)
  );

  wire rise_w = sync_dly & ~sync_prev_r;
  wire pn_hit_w = pn_shift_r == PN_CODE;
  wire init_w = (cfg.pulse_en & rise_w) | (cfg.pn_mode & pn_hit_w);
  wire txen_lvl_w = txen_meta_r[1] ^ cfg.txen_invert;
  wire txen_rise_w = data_clk_en_i & txen_lvl_w & ~txen_prev_r;

  // Loading with the offset of the clock-state field moves the derived clocks one step
  // per code; the hit cycle is skipped so a correctly spaced reload changes nothing.
  assign state_nxt = init_w ? {1'b0, cfg.clk_state} : 5'(state_r + 5'h0_1);

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_prev_r <= 1'b0;
      txen_prev_r <= 1'b0;
      pn_shift_r <= '0;
      state_r <= 5'h0_0;
      init_r <= 1'b0;
      nco_rst_r <= 1'b0;
    end
    else
    begin
      sync_prev_r <= sync_dly;
      if (data_clk_en_i)
        txen_prev_r <= txen_lvl_w;
      pn_shift_r <= {pn_shift_r[PN_LEN-2:0], sync_dly};
      state_r <= state_nxt;
      init_r <= init_w & ~init_r;
      // Pulse mode: strobe resets the phase accumulator; PN mode: the code match
      // carries the master's phase epoch and resets it at the same instant.
      nco_rst_r <= (cfg.pulse_en & txen_rise_w) | (cfg.pn_mode & pn_hit_w);
    end
  end

  // The flag holds until software writes a one; a new error in that cycle wins.
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      err_flag_r <= 1'b0;
      err_type_r <= 1'b0;
    end
    else if (marg_err)
    begin
      err_flag_r <= 1'b1;
      err_type_r <= marg_hold;
    end
    else if (clr_err_w)
      err_flag_r <= 1'b0;
  end

  assign init_pulse_o = init_r;
  assign clk_state_o = state_r;
  assign nco_reset_o = nco_rst_r;
  // Open drain: the pin is pulled low only while an enabled flag stands.
  assign irq_n_o = 1'b0;
  assign irq_n_oe_o = err_flag_r & irq_en_r;

  a_init_width: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    init_pulse_o |=> !init_pulse_o)
    else $error("init pulse longer than one cycle");

  a_pulse_fire: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (cfg.pulse_en && rise_w && !init_r) |=> init_pulse_o)
    else $error("sync rise gave no init pulse");

  a_pn_fire: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (cfg.pn_mode && pn_hit_w && !init_r) |=> init_pulse_o)
    else $error("code match gave no init pulse");

  a_state_load: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    init_w |=> state_r == {1'b0, $past(cfg.clk_state)})
    else $error("clock state not loaded");

  a_state_wrap: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (!init_w && state_r == 5'h1_f) |=> state_r == 5'h0_0)
    else $error("clock state did not wrap");

  a_nco_strobe: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (cfg.pulse_en && txen_rise_w) |=> nco_reset_o)
    else $error("strobe did not reset nco");

  a_err_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (err_flag_r && !clr_err_w) |=> err_flag_r)
    else $error("error flag dropped");

  a_err_set: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    marg_err |=> err_flag_r)
    else $error("margin error not flagged");

  a_err_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (clr_err_w && !marg_err) |=> !err_flag_r)
    else $error("error flag not cleared");

  a_irq_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    irq_n_oe_o == (err_flag_r && irq_en_r))
    else $error("irq gating wrong");
endmodule

//--- tb/mcsr_sync_src.sv
// Model of the sync source: one-shot sync pulses or a PN code burst, and a data clock enable.
// Assumes one clock shared with the receiver; the testbench spaces the bursts.
`timescale 1ns/1ps
module mcsr_sync_src #(
  parameter logic [31:0] CODE = 32'h0000_0000
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic fire_i,
  input wire logic pn_i,
  input wire logic [3:0] width_i,
  output logic sync_o,
  output logic dclk_en_o
);
  logic [5:0] cnt_r;
  logic [31:0] sh_r;
  logic [1:0] div_r;
  logic pn_r;
  // The data clock runs at a quarter of the sample rate; sync can change on every sample clock.
  assign dclk_en_o = (div_r == 2'd0);
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r <= '0;
      sh_r <= '0;
      div_r <= '0;
      pn_r <= 1'b0;
      sync_o <= 1'b0;
    end
    else
    begin
      div_r <= div_r + 2'd1;
      if (fire_i)
      begin
        cnt_r <= pn_i ? 6'd32 : {2'b00, width_i};
        sh_r <= CODE;
        pn_r <= pn_i;
      end
      else if (cnt_r != 6'd0)
      begin
        // Every edge is launched on a sample clock edge, one valid window for all.
        cnt_r <= cnt_r - 6'd1;
        sync_o <= pn_r ? sh_r[31] : 1'b1;
        sh_r <= {sh_r[30:0], 1'b0};
      end
      else
      begin
        sync_o <= 1'b0;
      end
    end
  end
endmodule

//--- tb/tb.sv
// Self-checking bench for the sync receive block, driven over APB.
// Assumes the sync source model drives the sync pin and the data clock enable.
`timescale 1ns/1ps
module tb;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, txen, fire, pn, sync, dcen;
  logic init, nco, irq_n, irq_oe, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] st;
  logic [4:0] d;
  logic [3:0] wid, cs;
  int mismatches, samples_checked, lat, lat0;
  mcsr_top i_mcsr_top (.core_clk_i(clk), .rst_n_i(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sync_pin_i(sync), .txen_pin_i(txen), .data_clk_en_i(dcen),
    .init_pulse_o(init), .clk_state_o(st), .nco_reset_o(nco), .irq_n_o(irq_n),
    .irq_n_oe_o(irq_oe));
  mcsr_sync_src #(.CODE(mcsr_pkg::PN_CODE_DEF)) i_mcsr_sync_src (.clk_i(clk),
    .rst_n_i(rst_n), .fire_i(fire), .pn_i(pn), .width_i(wid), .sync_o(sync), .dclk_en_o(dcen));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts negedges until the chosen pulse shows; 80 means it never came.
  task automatic await(input bit which, output int n);
    n = 0;
    @(negedge clk);
    while ((which ? nco : init) !== 1'b1 && n < 80)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic send(input logic p, input logic [3:0] w);
    @(posedge clk);
    fire <= 1'b1;
    pn <= p;
    wid <= w;
    @(posedge clk);
    fire <= 1'b0;
  endtask
  function automatic logic [31:0] cfg(input logic [3:0] c, input logic [4:0] dl,
    input logic [3:0] m);
    return 32'h0400_0000 | (32'(dl) << 19) | (32'(c) << 4) | 32'(m);
  endfunction
  initial
  begin
    #100000;
    mismatches++;
    stop_test();
  end
  initial
  begin
    {rst_n, psel, penable, pwrite, txen, fire, pn} = '0;
    paddr = '0;
    pwdata = '0;
    wid = '0;
    lat0 = 0;
    void'($urandom(73111));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, mcsr_pkg::ADDR_CTRL1, 0);
    chk("ctrl reset", mcsr_pkg::CTRL1_RST, rd);
    apb(0, mcsr_pkg::ADDR_SYNC_CFG, 0);
    chk("cfg reset", mcsr_pkg::SYNC_CFG_RST, rd);
    apb(0, 8'h30, 0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    apb(1, mcsr_pkg::ADDR_CTRL1, 32'h0000_0800);
    for (int i = 0; i < 5; i++)
    begin
      cs = 4'($urandom);
      d = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom);
      apb(1, mcsr_pkg::ADDR_SYNC_CFG, cfg(cs, d, 4'h0));
      apb(0, mcsr_pkg::ADDR_SYNC_CFG, 0);
      chk("cfg readback", cfg(cs, d, 4'h0), rd);
      send(0, 4'h8);
      await(0, lat);
      if (i == 0)
        lat0 = lat;
      chk("init latency", lat0 + d, lat);
      // The state loads at the same edge that raises the pulse.
      chk("loaded state", cs, st);
      @(negedge clk);
      chk("init width", 0, init);
      repeat (31) @(negedge clk);
      chk("state period", cs, st);
      repeat (40) @(posedge clk);
    end
    apb(1, mcsr_pkg::ADDR_CTRL1, 0);
    send(0, 4'h8);
    await(0, lat);
    chk("init when off", 80, lat);
    apb(1, mcsr_pkg::ADDR_CTRL1, 32'h0000_0800);
    txen <= 1'b1;
    await(1, lat);
    chk("nco reset", 1, lat < 80);
    @(negedge clk);
    chk("nco width", 0, nco);
    apb(1, mcsr_pkg::ADDR_CTRL1, 32'h0000_4800);
    // Let a data clock edge see the inverted idle level before the strobe.
    repeat (8) @(posedge clk);
    txen <= 1'b0;
    await(1, lat);
    chk("nco inverted", 1, lat < 80);
    apb(1, mcsr_pkg::ADDR_CTRL1, 32'h0000_3000);
    apb(1, mcsr_pkg::ADDR_SYNC_CFG, cfg(0, 0, 0));
    send(1, 4'h0);
    await(0, lat);
    chk("code init", 1, lat < 80);
    apb(1, mcsr_pkg::ADDR_CTRL1, 32'h0000_0800);
    apb(1, mcsr_pkg::ADDR_SYNC_CFG, cfg(0, 0, 4'hf));
    apb(1, mcsr_pkg::ADDR_IRQ_STAT, 1);
    send(0, 4'h1);
    repeat (40) @(posedge clk);
    apb(0, mcsr_pkg::ADDR_IRQ_STAT, 0);
    chk("error flag", 1, rd[6]);
    chk("irq drive", 1, irq_oe);
    chk("irq level", 0, irq_n);
    apb(1, mcsr_pkg::ADDR_IRQ_STAT, 0);
    @(negedge clk);
    chk("irq masked", 0, irq_oe);
    apb(0, mcsr_pkg::ADDR_IRQ_STAT, 0);
    chk("flag held", 1, rd[6]);
    apb(1, mcsr_pkg::ADDR_IRQ_STAT, 32'h0000_0041);
    apb(0, mcsr_pkg::ADDR_IRQ_STAT, 0);
    chk("flag cleared", 0, rd[6]);
    stop_test();
  end
endmodule
